// *** epf_cfg.svh ***
// Constants of the EEPROM protection and flash command sequencer.
// Assumes a 32-bit AXI4-Lite slave port with an 8-bit byte address.
`ifndef EPF_CFG_SVH
`define EPF_CFG_SVH

// Register byte offsets
`define EPF_OFF_PROT   8'h00
`define EPF_OFF_STAT   8'h04
`define EPF_OFF_IDX    8'h08
`define EPF_OFF_PARM   8'h0C
`define EPF_OFF_MODE   8'h10

// Field positions
`define EPF_OPEN_BIT   7
`define EPF_SIZE_W     7
`define EPF_ST_COMMAND_COMPLETE_FLAG    7
`define EPF_ST_ACCESS_ERROR_FLAG  5
`define EPF_ST_PROTECT_VIOLATION_FLAG  4
`define EPF_ST_MG1     1
`define EPF_ST_MG0     0
`define EPF_MODE_LOCK  0

// Address map
`define EPF_EE_BASE    24'h10_0000
`define EPF_EE_STEP    25'h20
`define EPF_PF_LO      24'hFF_0000
`define EPF_PF_HI      24'hFF_FFFF
`define EPF_PF_END     26'h100_0000
`define EPF_BOOT_PHR   24'hFF_FE08
`define EPF_BOOT_MSB   23
`define EPF_PHR_STEP   24'h8

// Commands and parameter checks
`define EPF_CMD_VFY    8'h03
`define EPF_CMD_RD1    8'h04
`define EPF_IDX_VFY    3'h2
`define EPF_IDX_RD1    3'h1
`define EPF_RD1_MAX    16'h0007
`define EPF_ERASED     64'hFFFF_FFFF_FFFF_FFFF
`define EPF_FULL_SIZE  7'h7F

// Bus answers
`define EPF_RESP_OK    2'h0
`define EPF_RESP_SLV   2'h2

`endif

// *** epf_pkg.sv ***
// Types of the EEPROM protection and flash command sequencer.
// Assumes epf_cfg.svh is on the include path.
`include "epf_cfg.svh"

package epf_pkg;

   typedef enum logic [2:0] {
      EPF_BOOT = 3'h0,
      EPF_IDLE = 3'h1,
      EPF_VFY  = 3'h3,
      EPF_RD1  = 3'h5
   } epf_fsm_e;

   typedef enum logic [2:0] {
      EPF_R_PROT = 3'h0,
      EPF_R_STAT = 3'h1,
      EPF_R_IDX  = 3'h2,
      EPF_R_PARM = 3'h3,
      EPF_R_MODE = 3'h4,
      EPF_R_NONE = 3'h7
   } epf_reg_e;

   typedef struct packed {
      epf_fsm_e                 fsm;
      logic                     protOpen;
      logic [`EPF_SIZE_W-1:0]   protSize;
      logic                     command_complete_flag;
      logic                     access_error_flag;
      logic                     protect_violation_flag;
      logic                     mg1;
      logic                     mg0;
      logic                     modeLock;
      logic [2:0]               idx;
      logic [7:0][15:0]         parm;
      logic [23:0]              vAddr;
      logic [15:0]              vLeft;
      logic                     memReq;
      logic                     memInfo;
      logic [23:0]              memAddr;
      logic                     peAllow;
      logic                     peDeny;
      logic                     awHeld;
      logic                     wHeld;
      logic [7:0]               awAddr;
      logic [31:0]              wData;
      logic [3:0]               wStrb;
      logic                     awRdy;
      logic                     wRdy;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     arRdy;
      logic                     rvalid;
      logic [31:0]              rdata;
      logic [1:0]               rresp;
   } epf_state_s;

endpackage

// *** epf_prot_range.sv ***
// Protected EEPROM window check for program and erase requests.
// Assumes the size field is as wide as the implemented EEPROM needs.
`include "epf_cfg.svh"

module epf_prot_range
   import epf_pkg::*;
(
   // Protection setting
   input  wire logic                   protOpen,
   input  wire logic [`EPF_SIZE_W-1:0] protSize,
   // Request
   input  wire logic [23:0]            addr,
   input  wire logic                   blockErase,
   // Verdict
   output logic                        deny
);

   logic [24:0] limit;
   logic        inRange;

   // One 32-byte step per size count, first step always protected
   assign limit = {1'b0, `EPF_EE_BASE}
                + {13'h0, protSize, 5'h0} + `EPF_EE_STEP;
   assign inRange = ({1'b0, addr} >= {1'b0, `EPF_EE_BASE})
                 && ({1'b0, addr} < limit);
   // Any protection at all rules out a block erase
   assign deny = !protOpen && (blockErase || inRange);

endmodule

// *** epf_addr_check.sv ***
// Address checks for a section erase verify.
// Assumes program flash spans EPF_PF_LO to EPF_PF_HI.
`include "epf_cfg.svh"

module epf_addr_check
   import epf_pkg::*;
(
   // Section
   input  wire logic [23:0] startAddr,
   input  wire logic [15:0] phraseCount,
   // Faults
   output logic             badAddr,
   output logic             misaligned,
   output logic             crossesEnd
);

   logic [25:0] endAddr;

   assign endAddr    = {2'b00, startAddr} + {7'h0, phraseCount, 3'h0};
   assign badAddr    = (startAddr < `EPF_PF_LO)
                    || (startAddr > `EPF_PF_HI);
   assign misaligned = (startAddr[2:0] != 3'h0);
   assign crossesEnd = (endAddr > `EPF_PF_END);

endmodule

// *** epf_flash_seq.sv ***
// EEPROM protection register, erase verify and read-once sequencer.
// Assumes a flash read port that answers each held request with one
// memAck pulse carrying a big-endian 64-bit phrase.
`include "epf_cfg.svh"

// How it works
// - Open bit clear blocks program/erase in range
// - Range starts at EEPROM base, 32-byte steps
// - All-ones size protects the full 4K
// - Size field width matches the EEPROM
// - Accepted launch clears complete flag; done sets it
// - Blank-check failure sets both status bits
// - Verify needs parameter index two at launch
// - Verify refused in locked mode
// - Invalid global address gives access error
// - Misaligned phrase address gives access error
// - Section past flash end gives access error
// - Any verify or read-once read error sets upper status bit
// - Uncorrectable read error sets lower bit
// - Read-once reads one of 8 info-area phrases
// - Read-once code, index, first word back
// - Reset loads protection byte from flash
// - Protected write refused, violation flag set
// - Block erase refused while any protection
module epf_flash_seq
   import epf_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // AXI4-Lite write
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Flash read port
   output logic             memReq,
   output logic             memInfo,
   output logic [23:0]      memAddr,
   input  wire logic        memAck,
   input  wire logic [63:0] memRdata,
   input  wire logic        memErrAny,
   input  wire logic        memErrFatal,
   // Program and erase check port
   input  wire logic        peReq,
   input  wire logic [23:0] peAddr,
   input  wire logic        peBlockErase,
   output logic             peAllow,
   output logic             peDeny
);

   epf_state_s  st;
   epf_state_s  next_st;
   logic        wrDo;
   logic        launch;
   logic        peBad;
   logic        badAddr;
   logic        misaligned;
   logic        crossesEnd;
   logic [7:0]  cmd;
   logic [23:0] secAddr;
   logic [31:0] rdMux;
   logic [15:0] wMerged;

   function automatic epf_reg_e regSel(input logic [7:0] a);
      case (a)
         `EPF_OFF_PROT: regSel = EPF_R_PROT;
         `EPF_OFF_STAT: regSel = EPF_R_STAT;
         `EPF_OFF_IDX:  regSel = EPF_R_IDX;
         `EPF_OFF_PARM: regSel = EPF_R_PARM;
         `EPF_OFF_MODE: regSel = EPF_R_MODE;
         default:       regSel = EPF_R_NONE;
      endcase
   endfunction

   // Word 0 carries the command code and address bits 23:16
   assign cmd     = st.parm[0][15:8];
   assign secAddr = {st.parm[0][7:0], st.parm[1]};
   assign wMerged = {st.wStrb[1] ? st.wData[15:8] : st.parm[st.idx][15:8],
                     st.wStrb[0] ? st.wData[7:0]  : st.parm[st.idx][7:0]};

   epf_prot_range u_prot (
      .protOpen   (st.protOpen),
      .protSize   (st.protSize),
      .addr       (peAddr),
      .blockErase (peBlockErase),
      .deny       (peBad)
   );

   epf_addr_check u_addr (
      .startAddr   (secAddr),
      .phraseCount (st.parm[2]),
      .badAddr     (badAddr),
      .misaligned  (misaligned),
      .crossesEnd  (crossesEnd)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register read view

   always_comb begin
      rdMux = 32'h0000_0000;
      case (regSel(araddr))
         EPF_R_PROT: begin
            rdMux[`EPF_OPEN_BIT]      = st.protOpen;
            rdMux[`EPF_SIZE_W-1:0]    = st.protSize;
         end
         EPF_R_STAT: begin
            rdMux[`EPF_ST_COMMAND_COMPLETE_FLAG]   = st.command_complete_flag;
            rdMux[`EPF_ST_ACCESS_ERROR_FLAG] = st.access_error_flag;
            rdMux[`EPF_ST_PROTECT_VIOLATION_FLAG] = st.protect_violation_flag;
            rdMux[`EPF_ST_MG1]    = st.mg1;
            rdMux[`EPF_ST_MG0]    = st.mg0;
         end
         EPF_R_IDX:  rdMux[2:0]   = st.idx;
         EPF_R_PARM: rdMux[15:0]  = st.parm[st.idx];
         EPF_R_MODE: rdMux[`EPF_MODE_LOCK] = st.modeLock;
         default:    rdMux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st = st;
      launch  = 1'b0;
      wrDo    = st.awHeld && st.wHeld && !st.bvalid;
      next_st.peAllow = 1'b0;
      next_st.peDeny  = 1'b0;

      // Address and data are taken in either order, then applied together
      if (awvalid && st.awRdy) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = awaddr;
      end
      if (wvalid && st.wRdy) begin
         next_st.wHeld = 1'b1;
         next_st.wData = wdata;
         next_st.wStrb = wstrb;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (wrDo) begin
         next_st.awHeld = 1'b0;
         next_st.wHeld  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = (regSel(st.awAddr) == EPF_R_NONE) ?
                          `EPF_RESP_SLV : `EPF_RESP_OK;
         case (regSel(st.awAddr))
            EPF_R_PROT: begin
               if (st.wStrb[0]) begin
                  next_st.protOpen = st.wData[`EPF_OPEN_BIT];
                  next_st.protSize = st.wData[`EPF_SIZE_W-1:0];
               end
            end
            EPF_R_STAT: begin
               if (st.wStrb[0]) begin
                  if (st.wData[`EPF_ST_ACCESS_ERROR_FLAG]) begin
                     next_st.access_error_flag = 1'b0;
                  end
                  if (st.wData[`EPF_ST_PROTECT_VIOLATION_FLAG]) begin
                     next_st.protect_violation_flag = 1'b0;
                  end
                  launch = st.wData[`EPF_ST_COMMAND_COMPLETE_FLAG] && st.command_complete_flag
                        && (st.fsm == EPF_IDLE);
               end
            end
            EPF_R_IDX: begin
               // Parameters are frozen while a command runs
               if (st.wStrb[0] && st.command_complete_flag) begin
                  next_st.idx = st.wData[2:0];
               end
            end
            EPF_R_PARM: begin
               if (st.command_complete_flag) begin
                  next_st.parm[st.idx] = wMerged;
               end
            end
            EPF_R_MODE: begin
               if (st.wStrb[0]) begin
                  next_st.modeLock = st.wData[`EPF_MODE_LOCK];
               end
            end
            default: begin
            end
         endcase
      end
      next_st.awRdy = !next_st.awHeld && !next_st.bvalid;
      next_st.wRdy  = !next_st.wHeld && !next_st.bvalid;

      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid && st.arRdy) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rdMux;
         next_st.rresp  = (regSel(araddr) == EPF_R_NONE) ?
                          `EPF_RESP_SLV : `EPF_RESP_OK;
      end
      next_st.arRdy = !next_st.rvalid;

      // A pending error blocks a new launch until software clears it
      if (launch && !next_st.access_error_flag && !next_st.protect_violation_flag) begin
         next_st.mg1 = 1'b0;
         next_st.mg0 = 1'b0;
         case (cmd)
            `EPF_CMD_VFY: begin
               if ((st.idx != `EPF_IDX_VFY) || st.modeLock
                   || badAddr || misaligned || crossesEnd) begin
                  next_st.access_error_flag = 1'b1;
               end else begin
                  next_st.command_complete_flag  = 1'b0;
                  next_st.fsm   = EPF_VFY;
                  next_st.vAddr = secAddr;
                  next_st.vLeft = st.parm[2];
               end
            end
            `EPF_CMD_RD1: begin
               if ((st.idx != `EPF_IDX_RD1)
                   || (st.parm[1] > `EPF_RD1_MAX)) begin
                  next_st.access_error_flag = 1'b1;
               end else begin
                  next_st.command_complete_flag    = 1'b0;
                  next_st.fsm     = EPF_RD1;
                  next_st.memReq  = 1'b1;
                  next_st.memInfo = 1'b1;
                  next_st.memAddr = {18'h0, st.parm[1][2:0], 3'h0};
               end
            end
            default: next_st.access_error_flag = 1'b1;
         endcase
      end

      case (st.fsm)
         EPF_BOOT: begin
            if (!st.memReq) begin
               next_st.memReq  = 1'b1;
               next_st.memInfo = 1'b0;
               next_st.memAddr = `EPF_BOOT_PHR;
            end else if (memAck) begin
               next_st.memReq = 1'b0;
               next_st.fsm    = EPF_IDLE;
               next_st.command_complete_flag   = 1'b1;
               // A broken protection byte leaves the EEPROM fully guarded
               if (memErrFatal) begin
                  next_st.protOpen = 1'b0;
                  next_st.protSize = `EPF_FULL_SIZE;
               end else begin
                  next_st.protOpen = memRdata[`EPF_BOOT_MSB];
                  next_st.protSize = memRdata[`EPF_BOOT_MSB-1 -: `EPF_SIZE_W];
               end
            end
         end
         EPF_VFY: begin
            if (!st.memReq) begin
               if (st.vLeft == 16'h0000) begin
                  next_st.fsm  = EPF_IDLE;
                  next_st.command_complete_flag = 1'b1;
               end else begin
                  next_st.memReq  = 1'b1;
                  next_st.memInfo = 1'b0;
                  next_st.memAddr = st.vAddr;
               end
            end else if (memAck) begin
               if (memErrAny || memErrFatal) begin
                  next_st.mg1 = 1'b1;
               end
               if (memErrFatal) begin
                  next_st.mg0 = 1'b1;
               end
               if (memRdata != `EPF_ERASED) begin
                  next_st.mg1 = 1'b1;
                  next_st.mg0 = 1'b1;
               end
               next_st.vLeft = st.vLeft - 16'h0001;
               next_st.vAddr = st.vAddr + `EPF_PHR_STEP;
               if (st.vLeft == 16'h0001) begin
                  next_st.memReq = 1'b0;
                  next_st.fsm    = EPF_IDLE;
                  next_st.command_complete_flag   = 1'b1;
               end else begin
                  next_st.memAddr = st.vAddr + `EPF_PHR_STEP;
               end
            end
         end
         EPF_RD1: begin
            if (memAck) begin
               next_st.parm[2] = memRdata[63:48];
               next_st.mg1     = memErrAny || memErrFatal;
               next_st.mg0     = memErrFatal;
               next_st.memReq  = 1'b0;
               next_st.memInfo = 1'b0;
               next_st.fsm     = EPF_IDLE;
               next_st.command_complete_flag    = 1'b1;
            end
         end
         default: begin
         end
      endcase

      // The violation set comes last so it wins over a same-cycle clear
      if (peReq) begin
         if (peBad) begin
            next_st.peDeny = 1'b1;
            next_st.protect_violation_flag = 1'b1;
         end else begin
            next_st.peAllow = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign awready = st.awRdy;
   assign wready  = st.wRdy;
   assign bvalid  = st.bvalid;
   assign bresp   = st.bresp;
   assign arready = st.arRdy;
   assign rvalid  = st.rvalid;
   assign rdata   = st.rdata;
   assign rresp   = st.rresp;
   assign memReq  = st.memReq;
   assign memInfo = st.memInfo;
   assign memAddr = st.memAddr;
   assign peAllow = st.peAllow;
   assign peDeny  = st.peDeny;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_first_step_guarded: assert property (@(posedge core_clk)
      disable iff (!rstn) peReq && !st.protOpen && !peBlockErase
      && (peAddr >= 24'h10_0000) && (peAddr < 24'h10_0020) |=> peDeny)
      else $error("first 32 bytes not protected");
   a_open_allows: assert property (@(posedge core_clk)
      disable iff (!rstn) peReq && st.protOpen |=> peAllow && !peDeny)
      else $error("open protection still refused");
   a_full_size_top: assert property (@(posedge core_clk)
      disable iff (!rstn) peReq && !st.protOpen && !peBlockErase
      && (st.protSize == 7'h7F) |=> (peDeny == ($past(peAddr) >= 24'h10_0000
      && $past(peAddr) <= 24'h10_0FFF)))
      else $error("full size range wrong");
   a_viol_flag: assert property (@(posedge core_clk)
      disable iff (!rstn) peDeny |-> st.protect_violation_flag && !peAllow)
      else $error("refusal without violation flag");
   a_block_erase: assert property (@(posedge core_clk)
      disable iff (!rstn) peReq && peBlockErase && !st.protOpen |=> peDeny)
      else $error("block erase not refused");
   a_index_check: assert property (@(posedge core_clk)
      disable iff (!rstn) launch && !st.access_error_flag && !st.protect_violation_flag
      && (cmd == 8'h03) && (st.idx != 3'h2) |=> st.access_error_flag && st.command_complete_flag)
      else $error("wrong index not flagged");
   a_mode_check: assert property (@(posedge core_clk)
      disable iff (!rstn) launch && !st.protect_violation_flag && (cmd == 8'h03)
      && st.modeLock |=> st.access_error_flag && (st.fsm == EPF_IDLE))
      else $error("locked mode verify ran");
   a_misalign: assert property (@(posedge core_clk)
      disable iff (!rstn) launch && !st.protect_violation_flag && (cmd == 8'h03)
      && (st.parm[1][2:0] != 3'h0) |=> st.access_error_flag)
      else $error("misaligned start accepted");
   a_busy_in_verify: assert property (@(posedge core_clk)
      disable iff (!rstn) (st.fsm == EPF_VFY) |-> !st.command_complete_flag)
      else $error("complete flag set while verifying");
   a_last_done: assert property (@(posedge core_clk)
      disable iff (!rstn) (st.fsm == EPF_VFY) && st.memReq && memAck
      && (st.vLeft == 16'h0001) |=> st.command_complete_flag && (st.fsm == EPF_IDLE))
      else $error("verify end did not complete");
   a_blank_fail: assert property (@(posedge core_clk)
      disable iff (!rstn) (st.fsm == EPF_VFY) && st.memReq && memAck
      && (memRdata != 64'hFFFF_FFFF_FFFF_FFFF) |=> st.mg1 && st.mg0)
      else $error("blank failure not reported");
   a_read_errors: assert property (@(posedge core_clk)
      disable iff (!rstn) (st.fsm == EPF_VFY) && st.memReq && memAck
      && memErrAny |=> st.mg1 && (st.mg0 || !$past(memErrFatal)))
      else $error("read error not reported");
   a_fatal_error: assert property (@(posedge core_clk)
      disable iff (!rstn) (st.fsm == EPF_VFY) && st.memReq && memAck
      && memErrFatal |=> st.mg0 && st.mg1)
      else $error("fatal read error not reported");
   a_read_once_word: assert property (@(posedge core_clk)
      disable iff (!rstn) (st.fsm == EPF_RD1) && memAck
      |=> st.parm[2] == $past(memRdata[63:48]) && st.command_complete_flag)
      else $error("read-once word not returned");
   a_boot_load: assert property (@(posedge core_clk)
      disable iff (!rstn) (st.fsm == EPF_BOOT) && st.memReq && memAck
      && !memErrFatal |=> {st.protOpen, st.protSize}
      == $past(memRdata[23:16]))
      else $error("protection byte not loaded");

endmodule

// *** tb_top.sv ***
// Self-checking bench for the EEPROM protection and command sequencer.
// Assumes epf_cfg.svh and epf_pkg are compiled ahead of this file.
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
   miscompares++; \
   $display("mismatch at %0t: %h vs %h", $time, (a), (e)); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] PROT = 8'h00, STAT = 8'h04, IDX = 8'h08;
   localparam logic [7:0] PARM = 8'h0C, MODE = 8'h10;
   logic        core_clk = 0, rstn = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdVal, rdata;
   logic [3:0]  wstrb = 0;
   logic [1:0]  bresp, rresp, resp;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        memReq, memInfo, memAck = 0, memErrAny = 0;
   logic        memErrFatal = 0, errA = 0, errF = 0, seenInfo = 0;
   logic [23:0] memAddr, peAddr = 0, seenAddr = 0;
   logic [63:0] memRdata = 0, fill = 64'h0000_0000_0003_0000;
   logic        peReq = 0, peBlockErase = 0, peAllow, peDeny;
   int          miscompares = 0, tests_run = 0;

   always #25 core_clk = ~core_clk;

   epf_flash_seq u_epf_flash_seq (.core_clk(core_clk), .rstn(rstn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .memReq(memReq), .memInfo(memInfo), .memAddr(memAddr),
      .memAck(memAck), .memRdata(memRdata), .memErrAny(memErrAny),
      .memErrFatal(memErrFatal), .peReq(peReq), .peAddr(peAddr),
      .peBlockErase(peBlockErase), .peAllow(peAllow), .peDeny(peDeny));

   ////////////////////////////////////////////////////////////////////////
   // Flash array stand-in: data scrambles between acks so stale reads show
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         memAck <= 0;
      end else if (memReq && !memAck) begin
         memAck <= 1;
         memRdata <= fill;
         memErrAny <= errA;
         memErrFatal <= errF;
         seenAddr <= memAddr;
         seenInfo <= memInfo;
      end else begin
         memAck <= 0;
         memRdata <= ~memRdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task final_report;
      if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task fail;
      miscompares++;
      final_report();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      awaddr <= a; wdata <= d; wstrb <= 4'hF;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      resp = bresp;
      bready <= 0;
      if (n == 40) fail();
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge core_clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      rdVal = rdata;
      resp = rresp;
      rready <= 0;
      if (n == 40) fail();
   endtask

   // Polls status until the complete flag is back; leaves status in rdVal
   task automatic waitDone;
      int n;
      for (n = 0; n < 40; n++) begin
         rd(STAT);
         if (rdVal[7]) break;
      end
      if (n == 40) fail();
   endtask

   task automatic cmd(input logic [15:0] w0, w1, w2, input logic [2:0] ix);
      wr(IDX, 0); wr(PARM, {16'h0, w0});
      wr(IDX, 1); wr(PARM, {16'h0, w1});
      wr(IDX, 2); wr(PARM, {16'h0, w2});
      wr(IDX, {29'h0, ix});
      wr(STAT, 32'h80);
      waitDone();
   endtask

   // Two-phrase section verify; pending access error cleared afterwards
   task automatic vfy(input logic [23:0] a, input logic [2:0] ix,
                      input logic [31:0] e);
      cmd({8'h03, a[23:16]}, a[15:0], 16'h2, ix);
      `CHK(rdVal, e)
      wr(STAT, 32'h20);
   endtask

   task automatic pe(input logic [23:0] a, input logic be, input logic dn);
      @(posedge core_clk);
      peReq <= 1; peAddr <= a; peBlockErase <= be;
      @(posedge core_clk);
      peReq <= 0;
      #1 `CHK({peDeny, peAllow}, {dn, !dn})
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1;
      waitDone();
      rd(PROT); `CHK(rdVal, 32'h03)
      `CHK(resp, 2'h0)
      pe(24'h10_007F, 0, 1);
      pe(24'h10_0080, 0, 0);
      rd(STAT); `CHK(rdVal, 32'h90)
      pe(24'h10_0100, 1, 1);
      wr(PROT, 32'h00);
      pe(24'h10_001F, 0, 1);
      pe(24'h10_0020, 0, 0);
      wr(PROT, 32'h7F);
      pe(24'h10_0FFF, 0, 1);
      pe(24'h10_1000, 0, 0);
      wr(PROT, 32'h80);
      pe(24'h10_0000, 0, 0);
      pe(24'h10_0000, 1, 0);
      wr(STAT, 32'h10);
      rd(STAT); `CHK(rdVal, 32'h80)
      fill = 64'hFFFF_FFFF_FFFF_FFFF;
      vfy(24'hFF_0000, 2, 32'h80);
      `CHK({seenInfo, seenAddr}, 25'h0FF_0008)
      fill = 64'hFFFF_FFFF_FFFF_FFFE;
      vfy(24'hFF_0000, 2, 32'h83);
      fill = 64'hFFFF_FFFF_FFFF_FFFF;
      errA = 1;
      vfy(24'hFF_0000, 2, 32'h82);
      errF = 1;
      vfy(24'hFF_0000, 2, 32'h83);
      errA = 0;
      errF = 0;
      vfy(24'hFF_0000, 1, 32'hA0);
      vfy(24'h10_0000, 2, 32'hA0);
      vfy(24'hFF_0004, 2, 32'hA0);
      vfy(24'hFF_FFF8, 2, 32'hA0);
      vfy(24'hFF_FFF0, 2, 32'h80);
      wr(MODE, 32'h1);
      `CHK(resp, 2'h0)
      vfy(24'hFF_0000, 2, 32'hA0);
      wr(MODE, 32'h0);
      fill = 64'hA5C3_1111_2222_3333;
      cmd(16'h0400, 16'h5, 16'h0, 1);
      `CHK(rdVal, 32'h80)
      `CHK({seenInfo, seenAddr}, 25'h100_0028)
      wr(IDX, 2);
      rd(PARM); `CHK(rdVal, 32'hA5C3)
      cmd(16'h0400, 16'h8, 16'h0, 1);
      `CHK(rdVal, 32'hA0)
      wr(8'h14, 32'h1); `CHK(resp, 2'h2)
      rd(8'h14); `CHK({resp, rdVal}, 34'h2_0000_0000)
      final_report();
   end
endmodule
